/* bps_bridge_primary_status.sv */
// Primary-side bridge status register with device number capture and split flags.
//
// Operation
// - Bits 2:0 show the bridge's own function number, which is zero after reset.
// - A configuration write addressed to the bridge loads bits 7:3 from address bits 15:11.
// - A write counts as addressed only with write command, select, type 0 and function match.
// - Bits 15:8 read back the primary bus number held in the type 1 header.
// - The completer ID of split completions is built from bus, device and function numbers.
// - Bit 16 always reads 0 since the primary side has no 64-bit support.
// - Bit 17 reads 0 in forward mode and 1 in reverse mode.
// - In forward mode bit 18 sets on a discarded split completion; in reverse it reads 0.
// - In reverse mode bit 19 sets on an unexpected completion carrying our own ID.
// - Bit 20 sets when a split completion is cut short because the buffer is full.
// - Bit 21 sets when a split request is held back by the commitment limit.
// - The commitment limit bounds outstanding split requests, and all ones disables it.
`timescale 1ns/10ps
module bps_bridge_primary_status import bps_pkg::*; (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Bridge direction strap, high for reverse mode.
    input  wire logic        reverse_mode,
    // Primary bus number from the type 1 header.
    input  wire logic [7:0]  prim_bus_num,
    // Configuration access, address and data presented in one cycle.
    input  wire logic        cfg_start,
    input  wire logic [3:0]  cfg_cmd,
    input  wire logic        cfg_idsel,
    input  wire logic [31:0] cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_byte_en,
    // Read answer.
    output logic             cfg_rvalid,
    output logic [31:0]      cfg_rdata,
    // Split completion events on the primary bus.
    input  wire logic        cpl_discard,
    input  wire logic        cpl_overrun,
    input  wire logic        cpl_in_valid,
    input  wire logic [15:0] cpl_in_req_id,
    input  wire logic        cpl_in_expected,
    // Completer ID for our own split completions.
    output logic [15:0]      completer_id,
    // Split request forwarding to the primary bus.
    input  wire logic [15:0] commit_limit,
    input  wire logic        sreq_valid,
    input  wire logic [15:0] sreq_adq,
    output logic             sreq_grant,
    input  wire logic        sret_valid,
    input  wire logic [15:0] sret_adq
);

    // Decode and commitment tracker results.
    logic        wr_hit;
    logic        rd_hit;
    logic        reg_hit;
    logic [4:0]  addr_dev;
    logic        sreq_delayed;
    logic [16:0] outstanding;

    // Register state.
    logic [4:0]  dev_num_ff;
    logic [4:0]  nxt_dev_num;
    logic        discard_ff;
    logic        nxt_discard;
    logic        unexp_ff;
    logic        nxt_unexp;
    logic        overrun_ff;
    logic        nxt_overrun;
    logic        delayed_ff;
    logic        nxt_delayed;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Combinational helpers.
    logic [31:0] status_word;
    logic [15:0] own_id;
    logic        flag_wr;
    logic        unexp_hit;

    bps_cfg_decode u_decode (
        .cfg_start (cfg_start),
        .cfg_cmd   (cfg_cmd),
        .cfg_idsel (cfg_idsel),
        .cfg_addr  (cfg_addr),
        .wr_hit    (wr_hit),
        .rd_hit    (rd_hit),
        .reg_hit   (reg_hit),
        .addr_dev  (addr_dev)
    );

    bps_commit_track u_track (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .commit_limit (commit_limit),
        .sreq_valid   (sreq_valid),
        .sreq_adq     (sreq_adq),
        .sreq_grant   (sreq_grant),
        .sreq_delayed (sreq_delayed),
        .sret_valid   (sret_valid),
        .sret_adq     (sret_adq),
        .outstanding  (outstanding)
    );

    always_comb begin
        own_id       = bps_make_id(prim_bus_num, dev_num_ff, BPS_FUNC_NUM);
        completer_id = own_id;
        // The flag byte must be enabled, so a write to the low bytes keeps flags.
        flag_wr      = wr_hit && reg_hit && cfg_byte_en[BPS_FLAG_BYTE];
        unexp_hit    = cpl_in_valid && !cpl_in_expected
                       && (cpl_in_req_id == own_id);

        status_word = 32'h0000_0000;
        status_word[BPS_FUNC_LSB +: 3]  = BPS_FUNC_NUM;
        status_word[BPS_DEV_LSB +: 5]   = dev_num_ff;
        status_word[BPS_BUS_LSB +: 8]   = prim_bus_num;
        status_word[BPS_BIT_64]         = BPS_NO_64BIT;
        status_word[BPS_BIT_133]        = reverse_mode;
        status_word[BPS_BIT_DISCARD]    = discard_ff && !reverse_mode;
        status_word[BPS_BIT_UNEXP]      = unexp_ff && reverse_mode;
        status_word[BPS_BIT_OVERRUN]    = overrun_ff;
        status_word[BPS_BIT_DELAYED]    = delayed_ff;
        status_word[31:BPS_RSVD_LSB]    = BPS_RSVD_VAL;
    end

    // Device number and the four sticky flags; a set in the clearing cycle wins.
    always_comb begin
        nxt_dev_num = wr_hit ? addr_dev : dev_num_ff;
        nxt_discard = discard_ff;
        nxt_unexp   = unexp_ff;
        nxt_overrun = overrun_ff;
        nxt_delayed = delayed_ff;
        if (flag_wr) begin
            if (cfg_wdata[BPS_BIT_DISCARD]) begin
                nxt_discard = 1'b0;
            end
            if (cfg_wdata[BPS_BIT_UNEXP]) begin
                nxt_unexp = 1'b0;
            end
            if (cfg_wdata[BPS_BIT_OVERRUN]) begin
                nxt_overrun = 1'b0;
            end
            if (cfg_wdata[BPS_BIT_DELAYED]) begin
                nxt_delayed = 1'b0;
            end
        end
        if (cpl_discard) begin
            nxt_discard = 1'b1;
        end
        if (unexp_hit) begin
            nxt_unexp = 1'b1;
        end
        if (cpl_overrun) begin
            nxt_overrun = 1'b1;
        end
        if (sreq_delayed) begin
            nxt_delayed = 1'b1;
        end
        // A flag that is read-only in this mode is held at zero.
        if (reverse_mode) begin
            nxt_discard = 1'b0;
        end else begin
            nxt_unexp = 1'b0;
        end
    end

    // Read answer, one cycle after the address phase.
    always_comb begin
        nxt_rvalid = rd_hit && reg_hit;
        nxt_rdata  = (rd_hit && reg_hit) ? status_word : BPS_RDATA_RST;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dev_num_ff <= BPS_DEV_RST;
            discard_ff <= BPS_FLAGS_RST[0];
            unexp_ff   <= BPS_FLAGS_RST[1];
            overrun_ff <= BPS_FLAGS_RST[2];
            delayed_ff <= BPS_FLAGS_RST[3];
            rvalid_ff  <= 1'b0;
            rdata_ff   <= BPS_RDATA_RST;
        end else begin
            dev_num_ff <= nxt_dev_num;
            discard_ff <= nxt_discard;
            unexp_ff   <= nxt_unexp;
            overrun_ff <= nxt_overrun;
            delayed_ff <= nxt_delayed;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign cfg_rvalid = rvalid_ff;
    assign cfg_rdata  = rdata_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_func_zero: assert property (
        cfg_rvalid |-> cfg_rdata[2:0] == BPS_FUNC_NUM)
        else $error("function number field not zero");

    chk_dev_capture: assert property (
        wr_hit |=> dev_num_ff == $past(cfg_addr[15:11]))
        else $error("device number not captured on addressed write");

    chk_dev_hold: assert property (
        (cfg_start && (cfg_cmd == BPS_CMD_CFG_WR) && !cfg_idsel) |=> $stable(dev_num_ff))
        else $error("device number changed without select");

    chk_bus_alias: assert property (
        cfg_rvalid |-> cfg_rdata[15:8] == $past(prim_bus_num))
        else $error("bus number field does not follow header");

    chk_cpl_id: assert property (
        wr_hit ##1 !wr_hit |-> completer_id[7:3] == $past(cfg_addr[15:11]))
        else $error("completer id lacks captured device number");

    chk_no_wide: assert property (
        cfg_rvalid |-> !cfg_rdata[16] && cfg_rdata[31:22] == 10'h000)
        else $error("bit 16 or reserved bits set");

    chk_speed_mode: assert property (
        (rd_hit && reg_hit) |=> cfg_rdata[17] == $past(reverse_mode))
        else $error("133 MHz bit does not match mode");

    chk_discard_set: assert property (
        (cpl_discard && !reverse_mode) ##1 !reverse_mode |-> discard_ff)
        else $error("discard flag not set in forward mode");

    chk_discard_rev: assert property (
        reverse_mode |=> !discard_ff)
        else $error("discard flag set in reverse mode");

    chk_unexp_set: assert property (
        (unexp_hit && reverse_mode) ##1 reverse_mode |-> unexp_ff)
        else $error("unexpected completion flag not set");

    chk_overrun_set: assert property (
        cpl_overrun |=> overrun_ff)
        else $error("overrun flag not set");

    chk_delay_set: assert property (
        (sreq_valid && !sreq_grant) |=> delayed_ff)
        else $error("delayed flag not set on held request");

    chk_limit_open: assert property (
        (sreq_valid && commit_limit == BPS_LIMIT_ALL) |-> sreq_grant)
        else $error("request held with unlimited commitment");

    chk_limit_bound: assert property (
        sreq_grant && commit_limit != BPS_LIMIT_ALL |-> ({1'b0, outstanding}
            + {2'b00, sreq_adq}) <= {2'b00, commit_limit})
        else $error("grant exceeds commitment limit");

    chk_w1c_clear: assert property (
        (flag_wr && cfg_wdata[BPS_BIT_OVERRUN] && !cpl_overrun) |=> !overrun_ff)
        else $error("write of one did not clear overrun flag");

    chk_w0_keep: assert property (
        (overrun_ff && !(flag_wr && cfg_wdata[BPS_BIT_OVERRUN])) |=> overrun_ff)
        else $error("overrun flag lost without clearing write");

    chk_w1c_discard: assert property (
        (flag_wr && cfg_wdata[BPS_BIT_DISCARD] && !cpl_discard) |=> !discard_ff)
        else $error("write of one did not clear discard flag");

    chk_w1c_unexp: assert property (
        (flag_wr && cfg_wdata[BPS_BIT_UNEXP] && !unexp_hit) |=> !unexp_ff)
        else $error("write of one did not clear unexpected completion flag");

    chk_w1c_delayed: assert property (
        (flag_wr && cfg_wdata[BPS_BIT_DELAYED] && !sreq_delayed) |=> !delayed_ff)
        else $error("write of one did not clear delayed flag");

    // An event in the clearing cycle must survive, or software would miss it.
    chk_set_wins: assert property (
        (flag_wr && cfg_wdata[BPS_BIT_OVERRUN] && cpl_overrun) |=> overrun_ff)
        else $error("overrun event lost to a clearing write");

    chk_byte_gate: assert property (
        (wr_hit && reg_hit && !cfg_byte_en[BPS_FLAG_BYTE] && delayed_ff) |=> delayed_ff)
        else $error("flag cleared through a disabled byte lane");

    chk_unexp_fwd: assert property (
        !reverse_mode |=> !unexp_ff)
        else $error("unexpected completion flag set in forward mode");

    chk_read_answer: assert property (
        (rd_hit && reg_hit) |=> cfg_rvalid)
        else $error("addressed status read not answered");

    // Only checked with a finite limit; the open setting may saturate the count.
    chk_commit_add: assert property (
        (sreq_grant && !sret_valid && commit_limit != BPS_LIMIT_ALL)
        |=> outstanding == $past(outstanding) + $past(sreq_adq))
        else $error("granted request not added to commitment");

    cov_set_wins: cover property (flag_wr && cfg_wdata[BPS_BIT_OVERRUN] && cpl_overrun);
    cov_dev_write: cover property (wr_hit && reg_hit ##1 cfg_start && rd_hit);
    cov_set_on_clear: cover property (flag_wr && cfg_wdata[BPS_BIT_DELAYED] && sreq_delayed);
    cov_unexp_rev: cover property (unexp_hit && reverse_mode);
    cov_delay_grant: cover property (sreq_delayed ##[1:20] sreq_grant);

endmodule

/* bps_bridge_primary_status_bench.sv */
// Self-checking bench of the primary status register block driven through the bus model.
`timescale 1ns/10ps
module bps_bridge_primary_status_bench import bps_pkg::*; ;
    logic        sys_clk, sys_rst, reverse_mode, cfg_start, cfg_idsel, cfg_rvalid, g;
    logic        cpl_discard, cpl_overrun, cpl_in_valid, cpl_in_expected;
    logic        sreq_valid, sreq_grant, sret_valid;
    logic [3:0]  cfg_cmd, cfg_byte_en;
    logic [7:0]  prim_bus_num;
    logic [4:0]  cur_dev;
    logic [15:0] cpl_in_req_id, completer_id, commit_limit, sreq_adq, sret_adq, own_id;
    logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, w, a;
    int          err_total, n_compared;

    bps_bridge_primary_status dut_u (.sys_clk, .sys_rst, .reverse_mode, .prim_bus_num,
        .cfg_start, .cfg_cmd, .cfg_idsel, .cfg_addr, .cfg_wdata, .cfg_byte_en, .cfg_rvalid,
        .cfg_rdata, .cpl_discard, .cpl_overrun, .cpl_in_valid, .cpl_in_req_id,
        .cpl_in_expected, .completer_id, .commit_limit, .sreq_valid, .sreq_adq, .sreq_grant,
        .sret_valid, .sret_adq);
    bps_bus_model bus_u (.sys_clk, .cfg_start, .cfg_cmd, .cfg_idsel, .cfg_addr, .cfg_wdata,
        .cfg_byte_en, .cpl_discard, .cpl_overrun, .cpl_in_valid, .cpl_in_req_id,
        .cpl_in_expected, .sreq_valid, .sreq_adq, .sreq_grant, .sret_valid, .sret_adq);

    assign own_id = {prim_bus_num, cur_dev, 3'h0};

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [31:0] exp_word(input logic f21, f20, f19, f18);
        return {10'h000, f21, f20, f19, f18, reverse_mode, 1'b0, prim_bus_num, cur_dev, 3'h0};
    endfunction

    task automatic rd_status(output logic [31:0] word);
        bus_u.cfg_cycle(BPS_CMD_CFG_RD, 1'b1, {16'h0000, cur_dev, 3'h0, BPS_REG_OFFSET},
                        32'h0000_0000, 4'h0);
        @(negedge sys_clk);
        cmp1("read answer", 1'b1, cfg_rvalid);
        word = cfg_rdata;
    endtask

    task automatic wr_status(input logic [31:0] data, input logic [3:0] be);
        bus_u.cfg_cycle(BPS_CMD_CFG_WR, 1'b1, {16'h0000, cur_dev, 3'h0, BPS_REG_OFFSET},
                        data, be);
    endtask

    task automatic t_reset_value();
        rd_status(w);
        cmp32("reset word", exp_word(0, 0, 0, 0), w);
        cmp32("completer id", {16'h0000, own_id}, {16'h0000, completer_id});
        $display("test reset_value done");
    endtask

    task automatic t_dev_capture();
        cur_dev = 5'h13;
        bus_u.cfg_cycle(BPS_CMD_CFG_WR, 1'b1, {16'h0000, cur_dev, 3'h0, 8'h10}, '0, 4'hF);
        // Each of these misses one addressing condition and must leave the number alone.
        for (int i = 0; i < 4; i++) begin
            a = {16'h0000, 5'h0C, 3'h0, BPS_REG_OFFSET};
            if (i == 1) a[1:0] = 2'h1;
            if (i == 2) a[10:8] = 3'h1;
            bus_u.cfg_cycle((i == 3) ? BPS_CMD_CFG_RD : BPS_CMD_CFG_WR, i != 0, a, '0, 4'hF);
        end
        @(posedge sys_clk);
        prim_bus_num <= 8'hC3;
        rd_status(w);
        cmp32("captured device", exp_word(0, 0, 0, 0), w);
        cmp32("completer id", {16'h0000, own_id}, {16'h0000, completer_id});
        $display("test dev_capture done");
    endtask

    task automatic t_flags_forward();
        bus_u.event_pulse(2'h0, own_id, 1'b0);
        bus_u.event_pulse(2'h1, own_id, 1'b0);
        bus_u.event_pulse(2'h2, own_id, 1'b0);
        rd_status(w);
        cmp32("forward flags", exp_word(0, 1, 0, 1), w);
        wr_status(32'hFFFF_FFFF, 4'hB);
        rd_status(w);
        cmp32("flags without byte two", exp_word(0, 1, 0, 1), w);
        wr_status(32'hFFD0_0000, 4'hF);
        rd_status(w);
        cmp32("overrun cleared", exp_word(0, 0, 0, 1), w);
        wr_status(32'h0004_0000, 4'h4);
        rd_status(w);
        cmp32("discard cleared", exp_word(0, 0, 0, 0), w);
        $display("test flags_forward done");
    endtask

    task automatic t_flags_reverse();
        @(posedge sys_clk);
        reverse_mode <= 1'b1;
        bus_u.event_pulse(2'h0, own_id, 1'b0);
        bus_u.event_pulse(2'h2, own_id, 1'b1);
        bus_u.event_pulse(2'h2, own_id ^ 16'h0008, 1'b0);
        rd_status(w);
        cmp32("reverse no flags", exp_word(0, 0, 0, 0), w);
        bus_u.event_pulse(2'h2, own_id, 1'b0);
        rd_status(w);
        cmp32("unexpected set", exp_word(0, 0, 1, 0), w);
        wr_status(32'h0008_0000, 4'h4);
        rd_status(w);
        cmp32("unexpected cleared", exp_word(0, 0, 0, 0), w);
        @(posedge sys_clk);
        reverse_mode <= 1'b0;
        $display("test flags_reverse done");
    endtask

    task automatic t_commit();
        bus_u.split_offer(16'h000A, g);
        cmp1("grant within limit", 1'b1, g);
        bus_u.split_offer(16'h0007, g);
        cmp1("grant over limit", 1'b0, g);
        rd_status(w);
        cmp32("delayed set", exp_word(1, 0, 0, 0), w);
        bus_u.split_offer(16'h0006, g);
        cmp1("grant at limit", 1'b1, g);
        @(posedge sys_clk);
        commit_limit <= BPS_LIMIT_ALL;
        bus_u.split_offer(16'h8000, g);
        cmp1("grant unlimited", 1'b1, g);
        @(posedge sys_clk);
        commit_limit <= 16'h0010;
        bus_u.split_return(16'h8010);
        bus_u.split_offer(16'h0010, g);
        cmp1("grant after return", 1'b1, g);
        wr_status(32'h0020_0000, 4'h4);
        rd_status(w);
        cmp32("delayed cleared", exp_word(0, 0, 0, 0), w);
        $display("test commit done");
    endtask

    task automatic t_reset_again();
        bus_u.event_pulse(2'h1, own_id, 1'b0);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cur_dev = 5'h00;
        rd_status(w);
        cmp32("word after reset", exp_word(0, 0, 0, 0), w);
        $display("test reset_again done");
    endtask

    initial begin
        #(3000 * 40);
        err_total++;
        $display("Error watchdog expected end seen hang");
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        reverse_mode = 1'b0;
        prim_bus_num = 8'h5A;
        commit_limit = 16'h0010;
        cur_dev = 5'h00;
        err_total = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset_value();
        t_dev_capture();
        t_flags_forward();
        t_flags_reverse();
        t_commit();
        t_reset_again();
        end_of_test();
    end
endmodule

/* bps_bus_model.sv */
// Behavioural primary bus master and split requester facing the status register block.
`timescale 1ns/10ps
module bps_bus_model (
    // Clock.
    input  wire logic        sys_clk,
    // Configuration cycle.
    output logic             cfg_start,
    output logic [3:0]       cfg_cmd,
    output logic             cfg_idsel,
    output logic [31:0]      cfg_addr,
    output logic [31:0]      cfg_wdata,
    output logic [3:0]       cfg_byte_en,
    // Split completion events.
    output logic             cpl_discard,
    output logic             cpl_overrun,
    output logic             cpl_in_valid,
    output logic [15:0]      cpl_in_req_id,
    output logic             cpl_in_expected,
    // Split requests.
    output logic             sreq_valid,
    output logic [15:0]      sreq_adq,
    input  wire logic        sreq_grant,
    output logic             sret_valid,
    output logic [15:0]      sret_adq
);
    initial begin
        {cfg_start, cfg_cmd, cfg_idsel, cfg_addr, cfg_wdata, cfg_byte_en} = '0;
        {cpl_discard, cpl_overrun, cpl_in_valid, cpl_in_req_id, cpl_in_expected} = '0;
        {sreq_valid, sreq_adq, sret_valid, sret_adq} = '0;
    end

    // After the address phase the AD lines carry the inverted pattern, so stale values never
    // pass for a fresh cycle.
    task automatic cfg_cycle(input logic [3:0] cmd, input logic sel, input logic [31:0] addr,
                             input logic [31:0] data, input logic [3:0] be);
        @(posedge sys_clk);
        cfg_start   <= 1'b1;
        cfg_cmd     <= cmd;
        cfg_idsel   <= sel;
        cfg_addr    <= addr;
        cfg_wdata   <= data;
        cfg_byte_en <= be;
        @(posedge sys_clk);
        cfg_start   <= 1'b0;
        cfg_idsel   <= 1'b0;
        cfg_addr    <= ~addr;
        cfg_wdata   <= ~data;
    endtask

    // Kind 0 is a discard, 1 an overrun, 2 a received completion.
    task automatic event_pulse(input logic [1:0] kind, input logic [15:0] id, input logic ok);
        @(posedge sys_clk);
        cpl_discard     <= (kind == 2'h0);
        cpl_overrun     <= (kind == 2'h1);
        cpl_in_valid    <= (kind == 2'h2);
        cpl_in_req_id   <= id;
        cpl_in_expected <= ok;
        @(posedge sys_clk);
        {cpl_discard, cpl_overrun, cpl_in_valid} <= 3'h0;
        cpl_in_req_id   <= ~id;
    endtask

    // Offers a request for one cycle; it is counted at the closing edge if granted.
    task automatic split_offer(input logic [15:0] adq, output logic got);
        @(posedge sys_clk);
        sreq_valid <= 1'b1;
        sreq_adq   <= adq;
        @(negedge sys_clk);
        got = sreq_grant;
        @(posedge sys_clk);
        sreq_valid <= 1'b0;
        sreq_adq   <= ~adq;
    endtask

    task automatic split_return(input logic [15:0] adq);
        @(posedge sys_clk);
        sret_valid <= 1'b1;
        sret_adq   <= adq;
        @(posedge sys_clk);
        sret_valid <= 1'b0;
        sret_adq   <= ~adq;
    endtask
endmodule

/* bps_cfg_decode.sv */
// Decoder for configuration cycles aimed at the bridge and its status register.
`timescale 1ns/10ps
module bps_cfg_decode import bps_pkg::*; (
    // Address phase.
    input  wire logic        cfg_start,
    input  wire logic [3:0]  cfg_cmd,
    input  wire logic        cfg_idsel,
    input  wire logic [31:0] cfg_addr,
    // Decode results.
    output logic             wr_hit,
    output logic             rd_hit,
    output logic             reg_hit,
    output logic [4:0]       addr_dev
);

    logic self_sel;

    always_comb begin
        // Type 0 with our select line and function number.
        self_sel = cfg_start && cfg_idsel
                   && (cfg_addr[1:0] == BPS_CFG_TYPE0)
                   && (cfg_addr[10:8] == BPS_FUNC_NUM);
        wr_hit   = self_sel && (cfg_cmd == BPS_CMD_CFG_WR);
        rd_hit   = self_sel && (cfg_cmd == BPS_CMD_CFG_RD);
        reg_hit  = (cfg_addr[7:2] == BPS_REG_OFFSET[7:2]);
        addr_dev = cfg_addr[15:11];
    end

endmodule

/* bps_commit_track.sv */
// Tracker of outstanding forwarded split requests against the commitment limit.
`timescale 1ns/10ps
module bps_commit_track import bps_pkg::*; (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Limit in ADQ units.
    input  wire logic [15:0] commit_limit,
    // Split request offered for forwarding.
    input  wire logic        sreq_valid,
    input  wire logic [15:0] sreq_adq,
    output logic             sreq_grant,
    output logic             sreq_delayed,
    // Space handed back when a forwarded request completes.
    input  wire logic        sret_valid,
    input  wire logic [15:0] sret_adq,
    // Current commitment.
    output logic [16:0]      outstanding
);

    logic [16:0] outst_ff;
    logic [16:0] nxt_outst;
    logic [17:0] want;
    logic [16:0] freed;

    always_comb begin
        want = {1'b0, outst_ff} + {2'b00, sreq_adq};
        // All ones lets any request through, whatever is committed.
        sreq_grant = sreq_valid && ((commit_limit == BPS_LIMIT_ALL)
                     || (want <= {2'b00, commit_limit}));
        sreq_delayed = sreq_valid && !sreq_grant;
        freed = sret_valid ? {1'b0, sret_adq} : 17'h0_0000;
        nxt_outst = outst_ff;
        if (sreq_grant) begin
            // Saturates so an unlimited setting cannot wrap the count.
            nxt_outst = want[17] ? 17'h1_FFFF : want[16:0];
        end
        nxt_outst = (nxt_outst > freed) ? (nxt_outst - freed) : BPS_OUTST_RST;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            outst_ff <= BPS_OUTST_RST;
        end else begin
            outst_ff <= nxt_outst;
        end
    end

    assign outstanding = outst_ff;

endmodule

/* bps_pkg.sv */
// Constants, field layout and the identifier helper function of the primary status register block.
package bps_pkg;

    // Register placement and bus command codes.
    localparam logic [7:0]  BPS_REG_OFFSET   = 8'h84;
    localparam logic [3:0]  BPS_CMD_CFG_RD   = 4'hA;
    localparam logic [3:0]  BPS_CMD_CFG_WR   = 4'hB;
    localparam logic [1:0]  BPS_CFG_TYPE0    = 2'h0;

    // Field positions inside the 32-bit status word.
    localparam int          BPS_FUNC_LSB     = 0;
    localparam int          BPS_DEV_LSB      = 3;
    localparam int          BPS_BUS_LSB      = 8;
    localparam int          BPS_BIT_64       = 16;
    localparam int          BPS_BIT_133      = 17;
    localparam int          BPS_BIT_DISCARD  = 18;
    localparam int          BPS_BIT_UNEXP    = 19;
    localparam int          BPS_BIT_OVERRUN  = 20;
    localparam int          BPS_BIT_DELAYED  = 21;
    localparam int          BPS_RSVD_LSB     = 22;
    localparam int          BPS_FLAG_BYTE    = 2;

    // Values after reset and fixed values.
    localparam logic [2:0]  BPS_FUNC_NUM     = 3'h0;
    localparam logic [4:0]  BPS_DEV_RST      = 5'h00;
    localparam logic [3:0]  BPS_FLAGS_RST    = 4'h0;
    localparam logic [31:0] BPS_RDATA_RST    = 32'h0000_0000;
    localparam logic [16:0] BPS_OUTST_RST    = 17'h0_0000;
    localparam logic        BPS_NO_64BIT     = 1'b0;
    localparam logic [9:0]  BPS_RSVD_VAL     = 10'h000;

    // Commitment limit value that disables the space check.
    localparam logic [15:0] BPS_LIMIT_ALL    = 16'hFFFF;

    // Builds a bus/device/function identifier.
    function automatic logic [15:0] bps_make_id(input logic [7:0] bus,
                                                input logic [4:0] dev,
                                                input logic [2:0] func);
        bps_make_id = {bus, dev, func};
    endfunction

endpackage
